// ===== core/acs_map.svh
// register map, field positions, reset values and timing counts of the channel sequencer
// assumes inclusion by the sequencer core only; the package does not include it
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define ACS_CLK_HZ        100000000
`define ACS_MCLK_HZ       76800
`define ACS_MCLK_DIV      (`ACS_CLK_HZ / `ACS_MCLK_HZ)

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACS_OFS_CTRL      12'h000
`define ACS_OFS_CHAN_EN   12'h004
`define ACS_OFS_CHAN_SET  12'h008
`define ACS_OFS_STATUS    12'h00c
`define ACS_OFS_SETUP0    12'h020
`define ACS_OFS_SETUP7    12'h03c

// ----------------------------------------------------------------
// setup register fields
// ----------------------------------------------------------------
`define ACS_DEC_LSB       0
`define ACS_FT_LSB        12
`define ACS_ST_LSB        16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACS_SETUP_RST     32'h0000_0030
`define ACS_CHEN_RST      8'h01
`define ACS_CHSET_RST     24'h00_0000

// ----------------------------------------------------------------
// timing counts in main-clock cycles
// ----------------------------------------------------------------
`define ACS_SETTLE_BASE   24'd32
`define ACS_TCNV_UNIT     24'd32
`define ACS_AVG           24'd8
`define ACS_ORD_SINC4     24'd4
`define ACS_ORD_SINC3     24'd3
`define ACS_POST1_CNV     24'd2944
`define ACS_POST2_CNV     24'd3200
`define ACS_POST3_CNV     24'd3968
`define ACS_POST4_CNV     24'd4736
`define ACS_PP_SHORT      8'd28
`define ACS_PP_LONG       8'd62
`define ACS_PP_POST       8'd69

`endif

// ===== core/acs_pkg.sv
// types shared by the channel sequencer: bus carriers, filter codes, phases
// assumes nothing from acs_map.svh; the types and codes here stand on their own
`default_nettype none
package acs_pkg;

    // filter-type field codes
    typedef enum logic [3:0] {
        FT_SINC4     = 4'h0,
        FT_SINC4_AVG = 4'h1,
        FT_SINC3     = 4'h2,
        FT_SINC3_N60 = 4'h3,
        FT_SINC3_AVG = 4'h4,
        FT_POST1     = 4'h5,
        FT_POST2     = 4'h6,
        FT_POST3     = 4'h7,
        FT_POST4     = 4'h8
    } acs_ftype_t;

    // sequencer phases
    typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_CONVERT} acs_phase_t;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } acs_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } acs_apb_rsp_t;

    // controls toward the multiplexer, modulator and filter path
    typedef struct packed {
        logic [2:0]  input_crosspoint_switch;
        logic        mod_rst;
        logic        flt_rst;
        logic [3:0]  ftype;
        logic [10:0] decimation_value;
    } acs_fe_t;

endpackage : acs_pkg
`default_nettype wire

// ===== core/acs_seq.sv
// channel sequencer and conversion timing for the sigma-delta filter path
// assumes an apb master on clk, a front end that obeys the mux select and
// reset pulses, and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"

// Notes on behaviour
// - steps through enabled channels automatically
// - each channel uses its own setup
// - channel change resets modulator, filter, switches mux
// - settling never below 32 main-clock cycles
// - settle delay is 32 shifted by field
// - sinc4 first conversion is four periods
// - sinc3 and notch variant take three periods
// - averaging and post filters take one period
// - averaging period is (order+7) x 32 x decimation
// - post filters use fixed periods 2944..4736
// - post-processing 28, 62 or 69 cycles
// - decimation is an unsigned 11-bit value
// - first result: settle + ideal + post-processing
// - later results follow at settled period
// - first ready always later than settled spacing
// - switch at conversion end, overlap post-processing
// - sequence spacing is first time minus previous
// - shared setup sequence gives a fixed rate
// - sequencing never alters the filter settings
// - decimation 6 gives 40 and 36.36 rates
// - all timing counted in main-clock cycles
// - filter code 0011 is sinc3 with extra notch
// - settled ready spacing equals settled period
module acs_seq #(
    parameter int MCLK_DIV = `ACS_MCLK_DIV       // clk cycles per main-clock tick
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire acs_pkg::acs_apb_req_t apb_req,
    output acs_pkg::acs_apb_rsp_t      apb_rsp,
    output acs_pkg::acs_fe_t           fe,
    output logic                       drdy_n,
    output logic [2:0]                 drdy_chan
);

    // ----------------------------------------------------------------
    // main-clock enable
    // ----------------------------------------------------------------
    logic [15:0] div_cnt;                        // divider position
    wire         tick = (div_cnt == 16'(MCLK_DIV - 1));  // one-cycle main-clock pulse

    // the divider itself runs below, once the switch pulse is declared

    // ----------------------------------------------------------------
    // registers and apb slave
    // ----------------------------------------------------------------
    logic        run;                            // continuous conversion enable
    logic [7:0]  chan_en;                        // enabled channel mask
    logic [23:0] chan_set;                       // 3-bit setup index per channel
    logic [31:0] setup [8];                      // setup words
    logic [31:0] prdata_q;                       // registered read data
    logic [7:0]  conv_cnt;                       // results delivered, wraps

    wire [11:0] adr     = apb_req.paddr;
    wire        setup_p = apb_req.psel && !apb_req.penable;
    wire        wr_acc  = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire        hit_ctl = (adr == `ACS_OFS_CTRL);
    wire        hit_en  = (adr == `ACS_OFS_CHAN_EN);
    wire        hit_set = (adr == `ACS_OFS_CHAN_SET);
    wire        hit_sta = (adr == `ACS_OFS_STATUS);
    wire        hit_stp = (adr >= `ACS_OFS_SETUP0) && (adr <= `ACS_OFS_SETUP7)
                          && (adr[1:0] == 2'b00);
    wire [2:0]  stp_idx = adr[4:2];
    wire        mapped  = hit_ctl || hit_en || hit_set || hit_sta || hit_stp;
    // any write that changes the sequence restarts it from the lowest channel
    wire        cfg_wr  = wr_acc && (hit_en || hit_set || hit_stp);
    wire        run_wr  = wr_acc && hit_ctl;

    assign apb_rsp.pready  = 1'b1;               // zero wait states
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign apb_rsp.prdata  = prdata_q;

    // software writes land only on the access edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            run      <= 1'b0;
            chan_en  <= `ACS_CHEN_RST;
            chan_set <= `ACS_CHSET_RST;
            for (int i = 0; i < 8; i++)
                setup[i] <= `ACS_SETUP_RST;
        end
        else if (wr_acc)
        begin
            if (hit_ctl)
                run <= apb_req.pwdata[0];
            if (hit_en)
                chan_en <= apb_req.pwdata[7:0];
            if (hit_set)
                chan_set <= apb_req.pwdata[23:0];
            if (hit_stp)
                setup[stp_idx] <= apb_req.pwdata;
        end
    end

    // ----------------------------------------------------------------
    // timing functions
    // ----------------------------------------------------------------
    // settled conversion period in main-clock cycles
    function automatic logic [23:0] tcnv_of(input logic [3:0] ft, input logic [10:0] dec);
        logic [23:0] base;
        logic [23:0] res;
        base = 24'(dec) * `ACS_TCNV_UNIT;
        case (ft)
            acs_pkg::FT_SINC4_AVG: res = base * (`ACS_ORD_SINC4 + `ACS_AVG - 24'd1);
            acs_pkg::FT_SINC3_AVG: res = base * (`ACS_ORD_SINC3 + `ACS_AVG - 24'd1);
            acs_pkg::FT_POST1:     res = `ACS_POST1_CNV;
            acs_pkg::FT_POST2:     res = `ACS_POST2_CNV;
            acs_pkg::FT_POST3:     res = `ACS_POST3_CNV;
            acs_pkg::FT_POST4:     res = `ACS_POST4_CNV;
            default:               res = base;
        endcase
        // decimation zero would give no period at all; hold one cycle
        return (res == 24'd0) ? 24'd1 : res;
    endfunction : tcnv_of

    // ideal first conversion on a new channel
    function automatic logic [23:0] first_of(input logic [3:0] ft, input logic [10:0] dec);
        logic [23:0] t;
        t = tcnv_of(ft, dec);
        case (ft)
            acs_pkg::FT_SINC4:     return 24'(t * `ACS_ORD_SINC4);
            acs_pkg::FT_SINC3,
            acs_pkg::FT_SINC3_N60: return 24'(t * `ACS_ORD_SINC3);
            default:               return t;
        endcase
    endfunction : first_of

    // post-processing time
    function automatic logic [7:0] pp_of(input logic [3:0] ft, input logic [10:0] dec);
        case (ft)
            acs_pkg::FT_SINC4,
            acs_pkg::FT_SINC3,
            acs_pkg::FT_SINC3_N60: return (dec <= 11'h001) ? `ACS_PP_SHORT : `ACS_PP_LONG;
            acs_pkg::FT_SINC4_AVG,
            acs_pkg::FT_SINC3_AVG: return `ACS_PP_LONG;
            default:               return `ACS_PP_POST;
        endcase
    endfunction : pp_of

    // next enabled channel above cur, wrapping to the lowest
    function automatic logic [2:0] next_ch_of(input logic [2:0] cur, input logic [7:0] en);
        logic [2:0] r;
        logic       found;
        r     = cur;
        found = 1'b0;
        for (int i = 1; i <= 8; i++)
        begin
            if (!found && en[3'(cur + 3'(i))])
            begin
                r     = 3'(cur + 3'(i));
                found = 1'b1;
            end
        end
        return r;
    endfunction : next_ch_of

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    acs_pkg::acs_phase_t phase;                  // idle, settling or converting
    logic [2:0]  cur_ch;                         // channel now on the mux
    logic [3:0]  cur_ft;                         // latched filter type
    logic [10:0] cur_dec;                        // latched decimation
    logic [2:0]  cur_st;                         // latched settle code
    logic [23:0] cnt;                            // main-clock cycles left in phase
    logic [7:0]  pp_cnt;                         // post-processing cycles left
    logic [2:0]  pp_ch;                          // channel being post-processed
    logic        run_q;                          // run seen last cycle

    wire [3:0]  n_en     = 4'($countones(chan_en));
    wire        multi    = (n_en > 4'd1);
    wire        restart  = run && chan_en != 8'h00 && ((!run_q) || cfg_wr);
    wire        stop     = !run || chan_en == 8'h00;
    wire        conv_end = (phase == acs_pkg::PH_CONVERT) && tick && (cnt == 24'd1);
    wire        set_end  = (phase == acs_pkg::PH_SETTLE) && tick && (cnt == 24'd1);
    wire        pp_end   = (pp_cnt != 8'h00) && tick && (pp_cnt == 8'h01);
    // restart always begins at the lowest enabled channel
    wire [2:0]  tgt_ch   = restart ? next_ch_of(3'h7, chan_en) : next_ch_of(cur_ch, chan_en);
    // a sequence of several channels switches as soon as conversion ends
    wire        sw_pulse = !stop && (restart || (conv_end && multi));
    wire [2:0]  tgt_sel  = chan_set[3*tgt_ch +: 3];
    wire [31:0] tgt_stp  = setup[tgt_sel];
    wire [3:0]  tgt_ft   = tgt_stp[`ACS_FT_LSB +: 4];
    wire [10:0] tgt_dec  = tgt_stp[`ACS_DEC_LSB +: 11];
    wire [2:0]  tgt_st   = tgt_stp[`ACS_ST_LSB +: 3];
    wire [23:0] tgt_set  = `ACS_SETTLE_BASE << tgt_st;
    wire [23:0] cur_tcnv = tcnv_of(cur_ft, cur_dec);
    wire [23:0] cur_1st  = first_of(cur_ft, cur_dec);

    // one clock domain only; the 76.8 kHz rate is an enable, not a clock
    // a switch restarts the divider so settling counts whole ticks only
    always_ff @(posedge clk)
    begin
        if (sys_rst || tick || sw_pulse)
            div_cnt <= 16'h0000;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    // phase and channel control
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            phase   <= acs_pkg::PH_IDLE;
            cur_ch  <= 3'h0;
            cur_ft  <= 4'h0;
            cur_dec <= 11'h000;
            cur_st  <= 3'h0;
            cnt     <= 24'h00_0000;
            run_q   <= 1'b0;
        end
        else
        begin
            run_q <= run;
            if (stop)
                phase <= acs_pkg::PH_IDLE;
            else if (sw_pulse)
            begin
                // new channel takes its own setup, then settles
                phase   <= acs_pkg::PH_SETTLE;
                cur_ch  <= tgt_ch;
                cur_ft  <= tgt_ft;
                cur_dec <= tgt_dec;
                cur_st  <= tgt_st;
                cnt     <= tgt_set;
            end
            else if (set_end)
            begin
                phase <= acs_pkg::PH_CONVERT;
                cnt   <= cur_1st;
            end
            else if (conv_end)
                cnt <= cur_tcnv;             // single channel stays settled
            else if (tick && phase != acs_pkg::PH_IDLE)
                cnt <= cnt - 24'd1;
        end
    end

    // post-processing runs beside the next channel's settling
    always_ff @(posedge clk)
    begin
        if (sys_rst || stop)
        begin
            pp_cnt <= 8'h00;
            pp_ch  <= 3'h0;
        end
        else if (conv_end)
        begin
            pp_cnt <= pp_of(cur_ft, cur_dec);
            pp_ch  <= cur_ch;
        end
        else if (tick && pp_cnt != 8'h00)
            pp_cnt <= pp_cnt - 8'h01;
    end

    // data ready falls only when post-processing completes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            drdy_n    <= 1'b1;
            drdy_chan <= 3'h0;
            conv_cnt  <= 8'h00;
        end
        else if (pp_end)
        begin
            drdy_n    <= 1'b0;
            drdy_chan <= pp_ch;
            conv_cnt  <= conv_cnt + 8'h01;
        end
        else if (conv_end)
            drdy_n <= 1'b1;                  // next word being processed
    end

    // front-end controls; filter settings come only from the setup
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            fe <= '0;
        else
        begin
            fe.mod_rst <= sw_pulse;
            fe.flt_rst <= sw_pulse;
            if (sw_pulse)
            begin
                fe.input_crosspoint_switch <= tgt_ch;
                fe.ftype                   <= tgt_ft;
                fe.decimation_value        <= tgt_dec;
            end
        end
    end

    // read mux sampled in the setup phase so data stands through access
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prdata_q <= 32'h0000_0000;
        else if (setup_p)
        begin
            if (hit_ctl)
                prdata_q <= {31'h0, run};
            else if (hit_en)
                prdata_q <= {24'h00_0000, chan_en};
            else if (hit_set)
                prdata_q <= {8'h00, chan_set};
            else if (hit_sta)
                prdata_q <= {16'h0000, conv_cnt, 1'b0, drdy_chan,
                             phase, drdy_n, 1'b0};
            else if (hit_stp)
                prdata_q <= setup[stp_idx];
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_settle_min;
        @(posedge clk) disable iff (sys_rst)
        (phase == acs_pkg::PH_SETTLE) |-> (cnt <= 24'd4096)
            && ($past(sw_pulse) ? (cnt >= 24'd32 && div_cnt == 16'h0000) : 1'b1);
    endproperty
    a_settle_min: assert property (p_settle_min) else $error("settle shorter than 32");

    property p_settle_code;
        @(posedge clk) disable iff (sys_rst)
        sw_pulse |=> (cnt == (`ACS_SETTLE_BASE << cur_st)) && (phase == acs_pkg::PH_SETTLE);
    endproperty
    a_settle_code: assert property (p_settle_code) else $error("settle length wrong");

    property p_switch_resets;
        @(posedge clk) disable iff (sys_rst)
        sw_pulse |=> fe.mod_rst && fe.flt_rst && (fe.input_crosspoint_switch == cur_ch);
    endproperty
    a_switch_resets: assert property (p_switch_resets) else $error("switch without resets");

    property p_auto_step;
        @(posedge clk) disable iff (sys_rst)
        (conv_end && multi && run && !cfg_wr) |=> (cur_ch != $past(cur_ch)) && fe.mod_rst;
    endproperty
    a_auto_step: assert property (p_auto_step) else $error("sequence did not step");

    property p_single_stay;
        @(posedge clk) disable iff (sys_rst)
        (conv_end && n_en == 4'd1 && !cfg_wr && run) |=> (phase == acs_pkg::PH_CONVERT) && !fe.mod_rst;
    endproperty
    a_single_stay: assert property (p_single_stay) else $error("single channel switched");

    property p_first_len;
        @(posedge clk) disable iff (sys_rst)
        (set_end && !sw_pulse && !stop && cur_ft == acs_pkg::FT_SINC4
            && cur_dec != 11'h000) |=> (cnt == 24'(cur_dec) * 24'd128);
    endproperty
    a_first_len: assert property (p_first_len) else $error("first conversion length wrong");

    property p_sinc3_first;
        @(posedge clk) disable iff (sys_rst)
        (set_end && !sw_pulse && !stop && cur_ft == acs_pkg::FT_SINC3_N60
            && cur_dec != 11'h000)
            |=> (cnt == 24'(cur_dec) * 24'd96);
    endproperty
    a_sinc3_first: assert property (p_sinc3_first) else $error("notch first time wrong");

    property p_post1_period;
        @(posedge clk) disable iff (sys_rst)
        (cur_ft == acs_pkg::FT_POST1) |-> (cur_tcnv == 24'd2944) && (cur_1st == 24'd2944);
    endproperty
    a_post1_period: assert property (p_post1_period) else $error("post filter period wrong");

    property p_pp_short;
        @(posedge clk) disable iff (sys_rst)
        (conv_end && !stop && cur_ft == acs_pkg::FT_SINC4 && cur_dec <= 11'h001)
            |=> (pp_cnt == 8'd28);
    endproperty
    a_pp_short: assert property (p_pp_short) else $error("post-processing not 28");

    property p_drdy_fall;
        @(posedge clk) disable iff (sys_rst)
        $fell(drdy_n) |-> $past(tick) && ($past(pp_cnt) == 8'h01);
    endproperty
    a_drdy_fall: assert property (p_drdy_fall) else $error("ready fell early");

endmodule : acs_seq
`default_nettype wire

// ===== verif/acs_fe_model.sv
// front end model: multiplexer and modulator seen from the sequencer
// assumes fe is driven by acs_seq on clk with a synchronous reset
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// switch tracker
// ----------------------------------------------------------------
module acs_fe_model (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire acs_pkg::acs_fe_t fe,
    output logic [2:0]            cur_chan,   // channel the mux sits on
    output logic [7:0]            switches,   // number of reset pulses
    output logic                  pulse_bad   // sticky: split reset pulse
);
    // the mux only moves on a reset pulse; a lone filter reset is a fault
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur_chan  <= 3'h0;
            switches  <= 8'h00;
            pulse_bad <= 1'b0;
        end
        else if (fe.mod_rst | fe.flt_rst)
        begin
            cur_chan  <= fe.input_crosspoint_switch;
            switches  <= switches + 8'h01;
            pulse_bad <= pulse_bad | (fe.mod_rst ^ fe.flt_rst);
        end
    end
endmodule : acs_fe_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the channel sequencer timing
// assumes MCLK_DIV of 4, so one main-clock tick is four clk cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    acs_pkg::acs_apb_req_t req = '0;
    acs_pkg::acs_apb_rsp_t rsp;
    acs_pkg::acs_fe_t      fe;
    logic                  drdy_n;
    logic [2:0]            drdy_chan;
    logic [2:0]            cur_chan;
    logic [7:0]            switches;
    logic                  pulse_bad;
    int                    fails = 0;
    int                    checks_done = 0;
    int                    cyc = 0;
    logic [31:0]           q;
    logic                  e;
    int                    t0, t1, t2;

    always #5 clk = ~clk;
    acs_seq #(.MCLK_DIV(4)) acs_seq_inst (.clk(clk), .sys_rst(sys_rst), .apb_req(req),
        .apb_rsp(rsp), .fe(fe), .drdy_n(drdy_n), .drdy_chan(drdy_chan));
    acs_fe_model acs_fe_model_inst (.clk(clk), .sys_rst(sys_rst), .fe(fe),
        .cur_chan(cur_chan), .switches(switches), .pulse_bad(pulse_bad));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // cycle ceiling well above the roughly 30000 cycles the scenarios need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fails++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask : chk
    // times are bench counters; the window covers the one-tick alignment
    task automatic chk_t(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi)
        begin
            fails++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask : chk_t
    // one apb transfer; the idle cycle after it keeps drives one per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1)
            fails++;
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    // waits for a falling data-ready edge and returns its cycle count
    task automatic fall(output int t);
        int  n;
        logic last;
        last = drdy_n;
        for (n = 0; n < 20000; n++)
        begin
            @(posedge clk);
            if (last === 1'b1 && drdy_n === 1'b0)
                break;
            last = drdy_n;
        end
        if (n == 20000)
            fails++;
        t = cyc;
    endtask : fall
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, 12'h020, 32'h0);
        chk("setup0 reset", 32'h0000_0030, q);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask : t_regs
    // sinc4, decimation 1, settle code 0 on the lone channel
    task automatic t_single;
        apb(1'b1, 12'h020, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h1);
        t0 = cyc;
        fall(t1);
        chk_t("first time", 752, 760, t1 - t0);
        fall(t2);
        chk_t("settled spacing", 128, 128, t2 - t1);
        chk("one switch", 32'h1, {24'h0, switches});
        apb(1'b1, 12'h000, 32'h0);
    endtask : t_single
    // two channels with different setups and overlapping post-processing
    task automatic t_seq;
        apb(1'b1, 12'h004, 32'h0000_0003);
        apb(1'b1, 12'h008, 32'h0000_0008);
        apb(1'b1, 12'h020, 32'h0000_3002);
        apb(1'b1, 12'h024, 32'h0001_1001);
        apb(1'b1, 12'h000, 32'h1);
        fall(t0);
        chk("chan a", 32'h0, {29'h0, drdy_chan});
        fall(t1);
        chk("chan b", 32'h1, {29'h0, drdy_chan});
        chk("mux back", 32'h0, {29'h0, cur_chan});
        chk("ftype back", 32'h3, {28'h0, fe.ftype});
        chk("dec back", 32'h2, {21'h0, fe.decimation_value});
        chk_t("avg spacing", 1660, 1668, t1 - t0);
        fall(t2);
        chk("chan wrap", 32'h0, {29'h0, drdy_chan});
        chk_t("sinc3 spacing", 892, 900, t2 - t1);
        chk("pulse pair", 32'h0, {31'h0, pulse_bad});
        apb(1'b1, 12'h000, 32'h0);
    endtask : t_seq
    // lone channel on post filter 1; its decimation field must be ignored
    task automatic t_post;
        apb(1'b1, 12'h004, 32'h0000_0001);
        apb(1'b1, 12'h020, 32'h0000_5006);
        apb(1'b1, 12'h000, 32'h1);
        t0 = cyc;
        fall(t1);
        chk_t("post first", 12180, 12188, t1 - t0);
        chk("post chan", 32'h0, {29'h0, drdy_chan});
        fall(t2);
        chk_t("post spacing", 11776, 11776, t2 - t1);
        apb(1'b1, 12'h000, 32'h0);
    endtask : t_post
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk("drdy idle", 32'h1, {31'h0, drdy_n});
        t_regs();
        t_single();
        t_seq();
        t_post();
        conclude();
    end
endmodule : tb
`default_nettype wire
